//--- pkg/afd_pkg.sv
// Purpose: Shared constants and types for the addition-family decoder
// Assumes: 8-bit opcodes, CPU clock 200 MHz
// Notes: Flag vector order is {c, z, s, v, d, h}
package afd_pkg;
   // ----------------------------------------
   // Opcode map
   // ----------------------------------------
   localparam logic [7:0] OP_SUM_FIRST = 8'h02;
   localparam logic [7:0] OP_SUM_LAST = 8'h07;
   localparam logic [7:0] OP_SUMC_FIRST = 8'h12;
   localparam logic [7:0] OP_SUMC_LAST = 8'h17;
   localparam logic [7:0] OP_WIDE_RR = 8'h08;
   localparam logic [7:0] OP_WIDE_RI = 8'h09;
   localparam logic [7:0] OP_WIDEC_RR = 8'h18;
   localparam logic [7:0] OP_WIDEC_RI = 8'h19;
   // ----------------------------------------
   // Cycle counts
   // ----------------------------------------
   localparam logic [2:0] FETCH_WORK = 3'h2;
   localparam logic [2:0] FETCH_FILE = 3'h3;
   localparam logic [2:0] FETCH_WIDE = 3'h4;
   localparam logic [2:0] EXEC_DIRECT = 3'h3;
   localparam logic [2:0] EXEC_INDIRECT = 3'h4;
   localparam logic [2:0] EXEC_WIDE = 3'h3;
   // ----------------------------------------
   // Flag positions and reset
   // ----------------------------------------
   localparam int FLG_C = 5;
   localparam int FLG_Z = 4;
   localparam int FLG_S = 3;
   localparam int FLG_V = 2;
   localparam int FLG_D = 1;
   localparam int FLG_H = 0;
   localparam logic [5:0] FLAGS_RST = 6'h00;
   localparam logic [7:0] RESULT_RST = 8'h00;
   // ----------------------------------------
   // Operand modes
   // ----------------------------------------
   typedef enum logic [3:0] {
      AFD_M_WORKING, AFD_M_PTR_WORK, AFD_M_FILE, AFD_M_PTR_FILE,
      AFD_M_CONST, AFD_M_WIDE, AFD_M_NONE
   } afd_mode_e;
   typedef enum logic [1:0] {AFD_IDLE, AFD_FETCH, AFD_EXEC} afd_state_e;
endpackage : afd_pkg

//--- verilog/afd_adder.sv
// Purpose: 8-bit adder producing result and arithmetic flags
// Assumes: Combinational, same clock domain as caller
// Notes: Decimal-adjust flag always returned as 0
`timescale 1ns/10ps
module afd_adder (
   input wire logic [7:0] a,
   input wire logic [7:0] b,
   input wire logic cin,
   output logic [7:0] sum,
   output logic [5:0] flags
);
   logic [8:0] full;
   logic [4:0] low;
   always_comb begin
      full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      sum = full[7:0];
      flags[afd_pkg::FLG_C] = full[8];
      flags[afd_pkg::FLG_Z] = (full[7:0] == 8'h00);
      flags[afd_pkg::FLG_S] = full[7];
      flags[afd_pkg::FLG_V] = (a[7] == b[7]) && (full[7] != a[7]);
      flags[afd_pkg::FLG_D] = 1'b0;
      flags[afd_pkg::FLG_H] = low[4];
   end
endmodule : afd_adder

//--- verilog/afd_decoder.sv
// Purpose: Decode and execute the addition instruction family
// Assumes: Operand values are supplied by the core alongside the opcode
// Notes: Accepts one opcode at a time while BUSY is low
//
// What this block does
// - Opcodes 02-07 add source to destination, six operand modes in order.
// - Opcodes 12-17 add source plus carry, same six operand modes.
// - Opcodes 08/09 wide add, wide or constant source, fetch 4, execute 3.
// - Opcodes 18/19 wide add with carry, fetch 4, execute 3.
// - Narrow forms fetch 2 cycles to working register, else 3.
// - Narrow forms execute 3 cycles direct, 4 with any indirect operand.
// - All sums set C Z S V H from result and clear D.
`timescale 1ns/10ps
module afd_decoder (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic START,
   input wire logic [7:0] OPCODE,
   input wire logic [7:0] DST_VAL,
   input wire logic [7:0] SRC_VAL,
   input wire logic CARRY_IN,
   output logic BUSY,
   output logic FETCHING,
   output logic DONE,
   output logic ILLEGAL,
   output logic [7:0] RESULT,
   output logic [5:0] FLAGS,
   output logic [3:0] DST_MODE,
   output logic [3:0] SRC_MODE
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      afd_pkg::afd_state_e state;
      logic busy;
      logic fetching;
      logic [2:0] cnt;
      logic [2:0] exec_len;
      logic [7:0] a;
      logic [7:0] b;
      logic use_c;
      logic cin;
      logic done;
      logic illegal;
      logic [7:0] result;
      logic [5:0] flags;
      afd_pkg::afd_mode_e dmode;
      afd_pkg::afd_mode_e smode;
   } afd_state_s;

   // Idle, nothing accepted, modes read as none
   localparam afd_state_s CUR_RST = '{
      state: afd_pkg::AFD_IDLE,
      busy: 1'b0,
      fetching: 1'b0,
      cnt: 3'h0,
      exec_len: 3'h0,
      a: 8'h00,
      b: 8'h00,
      use_c: 1'b0,
      cin: 1'b0,
      done: 1'b0,
      illegal: 1'b0,
      result: afd_pkg::RESULT_RST,
      flags: afd_pkg::FLAGS_RST,
      dmode: afd_pkg::AFD_M_NONE,
      smode: afd_pkg::AFD_M_NONE
   };

   afd_state_s cur_ff;
   afd_state_s nxt_st;
   logic [7:0] sum;
   logic [5:0] sum_flags;

   // Carry enters only for the with-carry forms
   afd_adder u_adder (
      .a(cur_ff.a),
      .b(cur_ff.b),
      .cin(cur_ff.use_c & cur_ff.cin),
      .sum(sum),
      .flags(sum_flags)
   );

   // ----------------------------------------
   // Decode helpers
   // ----------------------------------------
   logic legal;
   logic narrow;
   logic carry_fam;
   logic [2:0] fetch_len;
   logic [2:0] exec_len;
   afd_pkg::afd_mode_e dm;
   afd_pkg::afd_mode_e sm;
   logic [3:0] low_nib;

   always_comb begin
      low_nib = OPCODE[3:0];
      narrow = (OPCODE >= afd_pkg::OP_SUM_FIRST && OPCODE <= afd_pkg::OP_SUM_LAST)
         || (OPCODE >= afd_pkg::OP_SUMC_FIRST && OPCODE <= afd_pkg::OP_SUMC_LAST);
      legal = narrow || OPCODE == afd_pkg::OP_WIDE_RR || OPCODE == afd_pkg::OP_WIDE_RI
         || OPCODE == afd_pkg::OP_WIDEC_RR || OPCODE == afd_pkg::OP_WIDEC_RI;
      // Bit 4 separates the with-carry family from the plain one
      carry_fam = OPCODE[4];
   end

   // ----------------------------------------
   // Operand modes and cycle counts
   // ----------------------------------------
   always_comb begin
      dm = afd_pkg::AFD_M_NONE;
      sm = afd_pkg::AFD_M_NONE;
      fetch_len = afd_pkg::FETCH_WIDE;
      exec_len = afd_pkg::EXEC_WIDE;
      if (narrow) begin
         unique case (low_nib)
            4'h2: begin
               dm = afd_pkg::AFD_M_WORKING;
               sm = afd_pkg::AFD_M_WORKING;
            end
            4'h3: begin
               dm = afd_pkg::AFD_M_WORKING;
               sm = afd_pkg::AFD_M_PTR_WORK;
            end
            4'h4: begin
               dm = afd_pkg::AFD_M_FILE;
               sm = afd_pkg::AFD_M_FILE;
            end
            4'h5: begin
               dm = afd_pkg::AFD_M_FILE;
               sm = afd_pkg::AFD_M_PTR_FILE;
            end
            4'h6: begin
               dm = afd_pkg::AFD_M_FILE;
               sm = afd_pkg::AFD_M_CONST;
            end
            default: begin
               dm = afd_pkg::AFD_M_PTR_FILE;
               sm = afd_pkg::AFD_M_CONST;
            end
         endcase
         // Fetch follows the destination, execute grows with any indirect operand
         fetch_len = (dm == afd_pkg::AFD_M_WORKING) ? afd_pkg::FETCH_WORK : afd_pkg::FETCH_FILE;
         exec_len = (sm == afd_pkg::AFD_M_PTR_WORK || sm == afd_pkg::AFD_M_PTR_FILE
            || dm == afd_pkg::AFD_M_PTR_FILE) ? afd_pkg::EXEC_INDIRECT : afd_pkg::EXEC_DIRECT;
      end else if (legal) begin
         dm = afd_pkg::AFD_M_WIDE;
         sm = OPCODE[0] ? afd_pkg::AFD_M_CONST : afd_pkg::AFD_M_WIDE;
      end
   end

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always_comb begin
      nxt_st = cur_ff;
      nxt_st.done = 1'b0;
      unique case (cur_ff.state)
         afd_pkg::AFD_IDLE: begin
            nxt_st.illegal = 1'b0;
            if (START) begin
               if (legal) begin
                  nxt_st.state = afd_pkg::AFD_FETCH;
                  nxt_st.busy = 1'b1;
                  nxt_st.fetching = 1'b1;
                  nxt_st.cnt = fetch_len - 3'h1;
                  nxt_st.exec_len = exec_len;
                  // Operands are held here so the core may move on during the instruction
                  nxt_st.a = DST_VAL;
                  nxt_st.b = SRC_VAL;
                  nxt_st.use_c = carry_fam;
                  nxt_st.cin = CARRY_IN;
                  nxt_st.dmode = dm;
                  nxt_st.smode = sm;
               end else begin
                  nxt_st.illegal = 1'b1;
               end
            end
         end
         // START is not looked at here, so a request while busy is dropped
         afd_pkg::AFD_FETCH: begin
            if (cur_ff.cnt == 3'h1) begin
               nxt_st.state = afd_pkg::AFD_EXEC;
               nxt_st.fetching = 1'b0;
               nxt_st.cnt = cur_ff.exec_len;
            end else begin
               nxt_st.cnt = cur_ff.cnt - 3'h1;
            end
         end
         afd_pkg::AFD_EXEC: begin
            if (cur_ff.cnt == 3'h1) begin
               nxt_st.state = afd_pkg::AFD_IDLE;
               nxt_st.busy = 1'b0;
               nxt_st.done = 1'b1;
               nxt_st.result = sum;
               nxt_st.flags = sum_flags;
            end else begin
               nxt_st.cnt = cur_ff.cnt - 3'h1;
            end
         end
      endcase
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         cur_ff <= CUR_RST;
      end else begin
         cur_ff <= nxt_st;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // Every output is a field of the state flop, so none can glitch
   assign BUSY = cur_ff.busy;
   assign FETCHING = cur_ff.fetching;
   assign DONE = cur_ff.done;
   assign ILLEGAL = cur_ff.illegal;
   assign RESULT = cur_ff.result;
   assign FLAGS = cur_ff.flags;
   assign DST_MODE = cur_ff.dmode;
   assign SRC_MODE = cur_ff.smode;
endmodule : afd_decoder

//--- tb/afd_decoder_props.sv
// Purpose: Concurrent checks on the addition-family decoder ports
// Assumes: Single clock domain, asynchronous active-low reset
// Notes: Delays count from the edge that takes START
`timescale 1ns/10ps
module afd_decoder_props (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic START,
   input wire logic [7:0] OPCODE,
   input wire logic [7:0] DST_VAL,
   input wire logic [7:0] SRC_VAL,
   input wire logic BUSY,
   input wire logic FETCHING,
   input wire logic DONE,
   input wire logic ILLEGAL,
   input wire logic [7:0] RESULT,
   input wire logic [5:0] FLAGS
);
   logic tk;
   assign tk = START && !BUSY;
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);
   chk_work_done: assert property (tk && OPCODE inside {8'h02, 8'h12} |=> !DONE [*4] ##1 DONE)
      else $error("working form done time wrong");
   chk_six_done: assert property (tk && OPCODE inside {8'h03, 8'h13, 8'h04, 8'h06, 8'h14, 8'h16}
      |=> !DONE [*5] ##1 DONE) else $error("six cycle form done time wrong");
   chk_seven_done: assert property (tk
      && OPCODE inside {8'h05, 8'h07, 8'h15, 8'h17, 8'h08, 8'h09, 8'h18, 8'h19}
      |=> !DONE [*6] ##1 DONE) else $error("seven cycle form done time wrong");
   chk_fetch_short: assert property (tk && OPCODE inside {8'h02, 8'h03, 8'h12, 8'h13}
      |=> FETCHING ##1 !FETCHING) else $error("short fetch length wrong");
   chk_fetch_file: assert property (tk && OPCODE inside {[8'h04:8'h07], [8'h14:8'h17]}
      |=> FETCHING [*2] ##1 !FETCHING) else $error("file fetch length wrong");
   chk_fetch_wide: assert property (tk && OPCODE inside {8'h08, 8'h09, 8'h18, 8'h19}
      |=> FETCHING [*3] ##1 !FETCHING) else $error("wide fetch length wrong");
   chk_plain_sum: assert property (tk && OPCODE == 8'h04
      |-> ##6 RESULT == 8'($past(DST_VAL, 6) + $past(SRC_VAL, 6))) else $error("plain sum wrong");
   chk_flag_result: assert property (DONE |-> !FLAGS[1] && FLAGS[4] == (RESULT == 8'h00)
      && FLAGS[3] == RESULT[7]) else $error("flags disagree with result");
   chk_illegal_op: assert property (tk && !(OPCODE inside {[8'h02:8'h09], [8'h12:8'h19]})
      |=> ILLEGAL && !BUSY) else $error("foreign opcode not flagged");
endmodule : afd_decoder_props
bind afd_decoder afd_decoder_props u_props (.CLK, .RST_N, .START, .OPCODE, .DST_VAL, .SRC_VAL,
   .BUSY, .FETCHING, .DONE, .ILLEGAL, .RESULT, .FLAGS);

//--- tb/tb_afd_decoder.sv
// Purpose: Self-checking bench for the addition-family decoder
// Assumes: Inputs driven at the falling clock edge
// Notes: Expected sums, flags, modes and timings are worked out here
`timescale 1ns/10ps
module tb_afd_decoder;
   logic CLK = 1'b0;
   logic RST_N = 1'b0;
   logic START = 1'b0;
   logic CARRY_IN = 1'b0;
   logic [7:0] OPCODE = 8'h00, DST_VAL = 8'h00, SRC_VAL = 8'h00;
   logic BUSY, FETCHING, DONE, ILLEGAL;
   logic [7:0] RESULT;
   logic [5:0] FLAGS;
   logic [3:0] DST_MODE, SRC_MODE;
   int err_total = 0;
   int compares = 0;
   logic [3:0] dmt [2:9] = '{4'h0, 4'h0, 4'h2, 4'h2, 4'h2, 4'h3, 4'h5, 4'h5};
   logic [3:0] smt [2:9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h4, 4'h5, 4'h4};
   int cyt [2:9] = '{5, 6, 6, 7, 6, 7, 7, 7};
   logic [7:0] pv [6] = '{8'h7F, 8'h01, 8'hFF, 8'h01, 8'h08, 8'h08};
   always #2.5 CLK = ~CLK;
   afd_decoder uut (.CLK, .RST_N, .START, .OPCODE, .DST_VAL, .SRC_VAL, .CARRY_IN, .BUSY, .FETCHING,
      .DONE, .ILLEGAL, .RESULT, .FLAGS, .DST_MODE, .SRC_MODE);
   task end_sim;
      if (err_total == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_sim
   task cmp(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : cmp
   // Optional poke raises START again while busy; it must be ignored
   task run(input logic [7:0] op, input logic [7:0] d, input logic [7:0] s, input logic c, input logic poke);
      logic [8:0] r;
      logic [4:0] lo;
      logic ci;
      int n;
      ci = c & op[4];
      r = d + s + ci;
      lo = d[3:0] + s[3:0] + ci;
      START = 1'b1;
      OPCODE = op;
      DST_VAL = d;
      SRC_VAL = s;
      CARRY_IN = c;
      @(negedge CLK);
      START = poke;
      DST_VAL = ~d;
      cmp({BUSY, FETCHING}, 2'h3);
      @(negedge CLK);
      START = 1'b0;
      n = 2;
      while (DONE !== 1'b1 && n < 20) begin
         @(negedge CLK);
         n++;
      end
      cmp({BUSY, FETCHING}, 2'h0);
      cmp(n, cyt[op[3:0]]);
      cmp(RESULT, r[7:0]);
      cmp(FLAGS, {r[8], r[7:0] == 8'h00, r[7], d[7] == s[7] && r[7] != d[7], 1'b0, lo[4]});
      cmp(DST_MODE, dmt[op[3:0]]);
      cmp(SRC_MODE, smt[op[3:0]]);
   endtask : run
   task t_family(input logic [7:0] first, input logic [7:0] last, input logic c);
      for (int op = first; op <= last; op++) begin
         for (int k = 0; k < 6; k += 2) begin
            run(op[7:0], pv[k], pv[k + 1], c, 1'b0);
         end
      end
   endtask : t_family
   task t_refuse;
      run(8'h07, 8'h10, 8'h20, 1'b0, 1'b1);
   endtask : t_refuse
   task t_illegal;
      logic [7:0] bad [4] = '{8'h00, 8'h0A, 8'h11, 8'hFF};
      for (int i = 0; i < 4; i++) begin
         START = 1'b1;
         OPCODE = bad[i];
         @(negedge CLK);
         START = 1'b0;
         cmp({ILLEGAL, BUSY}, 2'h2);
         @(negedge CLK);
         cmp(ILLEGAL, 1'b0);
      end
   endtask : t_illegal
   initial begin
      #20000;
      err_total++;
      end_sim;
   end
   initial begin
      repeat (16) @(negedge CLK);
      cmp({BUSY, FETCHING, DONE, ILLEGAL, RESULT, FLAGS, DST_MODE, SRC_MODE}, 32'h66);
      RST_N = 1'b1;
      t_family(8'h02, 8'h07, 1'b1);
      t_family(8'h12, 8'h17, 1'b0);
      t_family(8'h12, 8'h17, 1'b1);
      t_family(8'h08, 8'h09, 1'b1);
      t_family(8'h18, 8'h19, 1'b0);
      t_family(8'h18, 8'h19, 1'b1);
      t_refuse;
      t_illegal;
      end_sim;
   end
endmodule : tb_afd_decoder
